// *** inc/cic_pkg.sv ***
// Shared constants, types and helpers for the cascaded interrupt controller pair
package cic_pkg;

  // ****************************************************************
  // I/O ports
  // ****************************************************************
  localparam logic [7:0] PORT_M_EVEN = 8'h20;
  localparam logic [7:0] PORT_M_ODD  = 8'h21;
  localparam logic [7:0] PORT_S_EVEN = 8'ha0;
  localparam logic [7:0] PORT_S_ODD  = 8'ha1;

  // ****************************************************************
  // Vectors and priorities
  // ****************************************************************
  localparam logic [7:0] VEC_BASE_M   = 8'h08;
  localparam logic [7:0] VEC_BASE_S   = 8'h70;
  localparam logic [7:0] SPURIOUS_OFS = 8'h07;
  localparam logic [3:0] CASCADE_IRQ  = 4'h2;
  localparam logic [3:0] PRIO_NONE    = 4'h8;

  // ****************************************************************
  // Field positions of written words
  // ****************************************************************
  localparam int INIT_FLAG_BIT = 4;
  localparam int LEVEL_BIT     = 3;
  localparam int AUTO_END_BIT  = 1;
  localparam int OCW3_BIT      = 3;
  localparam int END_CMD_BIT   = 5;
  localparam int SPEC_BIT      = 6;
  localparam int RDSEL_BIT     = 1;
  localparam int RDISR_BIT     = 0;

  typedef enum logic [1:0] {INIT_W2, INIT_W3, INIT_W4, INIT_READY} cic_init_e;

  // Index of the highest-priority set bit, bit 0 highest; PRIO_NONE if clear
  function automatic logic [3:0] cic_prio(input logic [7:0] v);
    logic [3:0] r;
    r = PRIO_NONE;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b0, 3'(i)};
      end
    end
    return r;
  endfunction : cic_prio

endpackage : cic_pkg

// *** rtl/cic_unit.sv ***
// One eight-input interrupt controller with its initialization sequencer
`timescale 1ns/1ps
module cic_unit #(
  parameter bit         IS_MASTER = 1'b1,
  parameter logic [7:0] VEC_BASE  = 8'h08
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // Port writes
  input  wire logic       wr_even_i,
  input  wire logic       wr_odd_i,
  input  wire logic [7:0] wdata_i,
  // Requests and acknowledge
  input  wire logic [7:0] req_i,
  input  wire logic       ack_i,
  // State
  output logic      [7:0] irr_o,
  output logic      [7:0] isr_o,
  output logic      [7:0] imr_o,
  output logic            int_o,
  output logic      [3:0] top_o,
  output logic      [7:0] vec_o,
  output logic      [7:0] rdata_even_o
);
  import cic_pkg::*;

  if (VEC_BASE[2:0] != 3'h0) begin : g_bad_base
    $error("vector base must be 8-aligned");
  end

  logic [7:0] irr;
  logic [7:0] isr;
  logic [7:0] imr;
  logic [7:0] req_q;
  logic       level_mode;
  logic       auto_end_en;
  logic       read_isr;
  cic_init_e  state;

  wire       init_one   = wr_even_i & wdata_i[INIT_FLAG_BIT];
  wire       ready      = (state == INIT_READY);
  wire       cmd_end    = wr_even_i & ~wdata_i[INIT_FLAG_BIT] & ~wdata_i[OCW3_BIT] & ready;
  wire       cmd_read   = wr_even_i & ~wdata_i[INIT_FLAG_BIT] & wdata_i[OCW3_BIT] & ready;
  wire       wr_mask    = wr_odd_i & ready;
  wire [7:0] pend       = irr & ~imr;
  wire [3:0] top_pend   = cic_prio(pend);
  wire [3:0] top_isr    = cic_prio(isr);
  wire       serve      = ack_i & (top_pend != PRIO_NONE);
  wire [7:0] serve_mask = serve ? (8'h01 << top_pend[2:0]) : 8'h00;
  wire       auto_end   = IS_MASTER & auto_end_en;
  wire       end_go     = cmd_end & wdata_i[END_CMD_BIT];
  wire [7:0] end_spec   = 8'h01 << wdata_i[2:0];
  wire [7:0] end_gen    = (top_isr == PRIO_NONE) ? 8'h00 : (8'h01 << top_isr[2:0]);
  wire [7:0] end_mask   = !end_go ? 8'h00 : (wdata_i[SPEC_BIT] ? end_spec : end_gen);
  wire [7:0] rise       = req_i & ~req_q;
  // Word one clears the pending bits; in edge mode a request held through it needs a fresh edge
  // In edge mode serving clears the request; a new edge in the same cycle wins
  wire [7:0] next_irr   = init_one   ? 8'h00 :
                          level_mode ? req_i : ((irr & ~serve_mask) | rise);
  wire [7:0] next_isr   = init_one ? 8'h00 :
                          ((isr & ~end_mask) | (auto_end ? 8'h00 : serve_mask));
  wire [7:0] next_imr   = init_one ? 8'h00 : (wr_mask ? wdata_i : imr);

  // Fully nested: only a request above every in-service level interrupts
  assign int_o        = ready & (top_pend < top_isr);
  assign top_o        = top_pend;
  assign vec_o        = VEC_BASE | {5'h00, top_pend[2:0]};
  assign irr_o        = irr;
  assign isr_o        = isr;
  assign imr_o        = imr;
  assign rdata_even_o = read_isr ? isr : irr;

  // ****************************************************************
  // Controller state, deliberately outside the reset
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    irr   <= next_irr;
    isr   <= next_isr;
    imr   <= next_imr;
    req_q <= req_i;
    if (init_one) begin
      state       <= INIT_W2;
      level_mode  <= wdata_i[LEVEL_BIT];
      auto_end_en <= 1'b0;
      read_isr    <= 1'b0;
    end else if (wr_odd_i && !ready) begin
      unique case (state)
        INIT_W2: begin
          state <= INIT_W3;
        end
        INIT_W3: begin
          state <= INIT_W4;
        end
        INIT_W4: begin
          auto_end_en <= wdata_i[AUTO_END_BIT];
          state       <= INIT_READY;
        end
        INIT_READY: begin
          state <= INIT_READY;
        end
      endcase
    end else if (cmd_read && wdata_i[RDSEL_BIT]) begin
      read_isr <= wdata_i[RDISR_BIT];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  init_restart_a: assert property (init_one |=> state == INIT_W2)
    else $error("first init word did not restart the sequencer");
  ptr_advance_a: assert property (wr_odd_i && !init_one && state == INIT_W2
                                  |=> state == INIT_W3)
    else $error("init pointer did not advance");
  serve_isr_a: assert property (serve && !auto_end && !init_one && !cmd_end
                                |=> (isr & $past(serve_mask)) != 8'h00)
    else $error("served request not marked in service");
  slave_no_auto_a: assert property (serve && !IS_MASTER && !init_one && !cmd_end
                                    |=> isr != 8'h00)
    else $error("slave ended service without a command");

endmodule : cic_unit

// *** rtl/cic_top.sv ***
// Cascaded interrupt controller pair with acknowledge and power-management paths
// Notes on behaviour
// - Master returns vectors 08h-0Fh for requests 0-7; request 2 has none.
// - Slave returns vectors 70h-77h for requests 8-15, ascending.
// - Controller works from power-on with no separate software enable.
// - Power-on reset leaves controller registers and sequencer state undefined.
// - Even-port write with bit 4 set is word one and restarts sequencing.
// - Master init words two to four go only through port 21h.
// - Each of the three odd-port writes after word one advances the pointer; only word four is stored.
// - Qualified indication when an unmasked request or in-service bit is set.
// - Qualified indications are combinatorial, no register stage.
// - Rising edge on enabled, mapped, selected pin 0-2 gives wake-up.
// - Rising edge on selected internal request gives activity, never wake.
// - Slave output is hardwired into master request input 2.
// - Automatic end of service in master only; slave needs the command.
// - After initialization priority is fully nested.
// - Only x86 vector bytes are produced, no call-instruction mode.
`timescale 1ns/1ps
module cic_top (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // I/O port access
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  // Interrupt requests and CPU acknowledge
  input  wire logic [15:0] irq_i,
  input  wire logic        inta_i,
  output logic             cpu_int_o,
  output logic      [7:0]  vector_o,
  output logic             vector_vld_o,
  // Power management unit
  input  wire logic [2:0]  ext_request_pins_low_i,
  input  wire logic [2:0]  ext_pin_en_i,
  input  wire logic [2:0]  ext_pin_mapped_i,
  input  wire logic [1:0]  chip_setup_index_sel_i,
  input  wire logic [15:0] act_sel_i,
  output logic      [15:0] qual_irq_o,
  output logic             wake_o,
  output logic             activity_o
);
  import cic_pkg::*;

  // ****************************************************************
  // Port decode
  // ****************************************************************
  wire m_even_wr = io_wr_i & (io_addr_i == PORT_M_EVEN);
  wire m_odd_wr  = io_wr_i & (io_addr_i == PORT_M_ODD);
  wire s_even_wr = io_wr_i & (io_addr_i == PORT_S_EVEN);
  wire s_odd_wr  = io_wr_i & (io_addr_i == PORT_S_ODD);

  logic [7:0] m_irr;
  logic [7:0] m_isr;
  logic [7:0] m_imr;
  logic [7:0] m_rd;
  logic [7:0] m_vec;
  logic [3:0] m_top;
  logic       m_int;
  logic [7:0] s_irr;
  logic [7:0] s_isr;
  logic [7:0] s_imr;
  logic [7:0] s_rd;
  logic [7:0] s_vec;
  logic [3:0] s_top;
  logic       s_int;

  // ****************************************************************
  // Cascaded pair
  // ****************************************************************
  wire [7:0] m_req   = {irq_i[7:3], s_int, irq_i[1:0]};
  wire       m_casc  = (m_top == CASCADE_IRQ);
  wire       s_ack   = inta_i & m_casc;

  // No enable gating: both units accept port writes from power-on
  cic_unit #(.IS_MASTER(1'b1), .VEC_BASE(VEC_BASE_M)) u_master (
    .ref_clk_i    (ref_clk_i),
    .rstn_i       (rstn_i),
    .wr_even_i    (m_even_wr),
    .wr_odd_i     (m_odd_wr),
    .wdata_i      (io_wdata_i),
    .req_i        (m_req),
    .ack_i        (inta_i),
    .irr_o        (m_irr),
    .isr_o        (m_isr),
    .imr_o        (m_imr),
    .int_o        (m_int),
    .top_o        (m_top),
    .vec_o        (m_vec),
    .rdata_even_o (m_rd)
  );

  cic_unit #(.IS_MASTER(1'b0), .VEC_BASE(VEC_BASE_S)) u_slave (
    .ref_clk_i    (ref_clk_i),
    .rstn_i       (rstn_i),
    .wr_even_i    (s_even_wr),
    .wr_odd_i     (s_odd_wr),
    .wdata_i      (io_wdata_i),
    .req_i        (irq_i[15:8]),
    .ack_i        (s_ack),
    .irr_o        (s_irr),
    .isr_o        (s_isr),
    .imr_o        (s_imr),
    .int_o        (s_int),
    .top_o        (s_top),
    .vec_o        (s_vec),
    .rdata_even_o (s_rd)
  );

  // ****************************************************************
  // Vector selection
  // ****************************************************************
  wire [7:0] m_spur   = VEC_BASE_M | SPURIOUS_OFS;
  wire [7:0] s_spur   = VEC_BASE_S | SPURIOUS_OFS;
  wire [7:0] s_pick   = (s_top == PRIO_NONE) ? s_spur : s_vec;
  wire [7:0] next_vec = (m_top == PRIO_NONE) ? m_spur :
                        (m_casc ? s_pick : m_vec);

  wire [7:0] next_rdata = !io_rd_i                       ? 8'h00 :
                          (io_addr_i == PORT_M_EVEN)     ? m_rd  :
                          (io_addr_i == PORT_M_ODD)      ? m_imr :
                          (io_addr_i == PORT_S_EVEN)     ? s_rd  :
                          (io_addr_i == PORT_S_ODD)      ? s_imr : 8'h00;

  // ****************************************************************
  // Power management paths
  // ****************************************************************
  // Left unregistered so a stopped clock can be restarted by them
  assign qual_irq_o = {(s_irr & ~s_imr) | s_isr, (m_irr & ~m_imr) | m_isr};

  logic [2:0]  ext_q;
  logic [15:0] irq_q;

  wire        func_sel  = |chip_setup_index_sel_i;
  wire [2:0]  ext_rise  = ext_request_pins_low_i & ~ext_q & ext_pin_en_i &
                          ext_pin_mapped_i & {3{func_sel}};
  // Activity only; no wake, SMI or NMI path exists from these edges
  wire [15:0] irq_rise  = irq_i & ~irq_q & act_sel_i;

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cpu_int_o    <= 1'b0;
      vector_o     <= 8'h00;
      vector_vld_o <= 1'b0;
      io_rdata_o   <= 8'h00;
      wake_o       <= 1'b0;
      activity_o   <= 1'b0;
      ext_q        <= 3'h0;
      irq_q        <= 16'h0000;
    end else begin
      cpu_int_o    <= m_int;
      vector_o     <= inta_i ? next_vec : vector_o;
      vector_vld_o <= inta_i;
      io_rdata_o   <= next_rdata;
      wake_o       <= |ext_rise;
      activity_o   <= |irq_rise;
      ext_q        <= ext_request_pins_low_i;
      irq_q        <= irq_i;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  master_vector_a: assert property (inta_i && m_top != PRIO_NONE && !m_casc
      |=> vector_vld_o && vector_o == (VEC_BASE_M | {5'h00, $past(m_top[2:0])}))
    else $error("wrong master vector");
  no_vector_two_a: assert property (vector_vld_o |-> vector_o != (VEC_BASE_M | 8'h02))
    else $error("vector for the cascade input returned");
  slave_vector_a: assert property (inta_i && m_casc && s_top != PRIO_NONE
      |=> vector_o == (VEC_BASE_S | {5'h00, $past(s_top[2:0])}))
    else $error("wrong slave vector");
  qual_service_a: assert property ((m_isr | s_isr) != 8'h00
      |-> (qual_irq_o & {s_isr, m_isr}) == {s_isr, m_isr})
    else $error("in-service level not reported to power management");
  // Checked in the very cycle the in-service bits move, so no register stage fits
  qual_comb_a: assert property ($changed(m_isr)
      |-> qual_irq_o[7:0] == ((m_irr & ~m_imr) | m_isr))
    else $error("qualified indication lagged the in-service change");
  wake_edge_a: assert property (|ext_rise |=> wake_o ##1 (wake_o == $past(|ext_rise)))
    else $error("wake-up missing after qualified pin edge");
  wake_gate_a: assert property (!func_sel |=> !wake_o)
    else $error("wake-up without function selected");
  activity_edge_a: assert property (|irq_rise |=> activity_o)
    else $error("activity missing after selected request edge");

  // ****************************************************************
  // Output timing and gating
  // ****************************************************************
  activity_gate_a: assert property (irq_rise == 16'h0000 |=> !activity_o)
    else $error("activity without a selected request edge");
  wake_pin_gate_a: assert property (ext_rise == 3'h0 |=> !wake_o)
    else $error("wake-up without a qualified pin edge");
  master_spur_a: assert property (inta_i && m_top == PRIO_NONE
      |=> vector_vld_o && vector_o == m_spur)
    else $error("wrong vector with nothing pending");
  vld_pulse_a: assert property (!inta_i |=> !vector_vld_o)
    else $error("vector strobe without an acknowledge");
  int_follow_a: assert property (m_int |=> cpu_int_o)
    else $error("processor interrupt lagged the master request");
  int_quiet_a: assert property (!m_int |=> !cpu_int_o)
    else $error("processor interrupt without a master request");
  rdata_idle_a: assert property (!io_rd_i |=> io_rdata_o == 8'h00)
    else $error("read data shown without a read");
  rdata_mask_a: assert property (io_rd_i && io_addr_i == PORT_M_ODD
      |=> io_rdata_o == $past(m_imr))
    else $error("mask read returned the wrong value");

  master_ack_c: cover property (inta_i && m_top != PRIO_NONE && !m_casc);
  slave_ack_c:  cover property (inta_i && m_casc && s_top != PRIO_NONE);
  wake_c:       cover property (wake_o);
  activity_c:   cover property (activity_o ##1 cpu_int_o);
  spur_c:       cover property (inta_i && m_top == PRIO_NONE);

endmodule : cic_top

// *** bench/cic_cpu_model.sv ***
// CPU acknowledge model: pulses the acknowledge on command and captures the vector
`timescale 1ns/1ps
module cic_cpu_model (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rstn_i,
  // Bench command
  input  wire logic       ack_go_i,
  // Controller side
  input  wire logic       vector_vld_i,
  input  wire logic [7:0] vector_i,
  output logic            inta_o,
  output logic      [7:0] got_vec_o,
  output logic            got_o
);
  // ****************************************************************
  // One acknowledge pulse per command, vector taken on its valid pulse
  // ****************************************************************
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      inta_o    <= 1'b0;
      got_o     <= 1'b0;
      got_vec_o <= 8'h00;
    end else begin
      inta_o <= ack_go_i;
      if (ack_go_i) begin
        got_o <= 1'b0;
      end
      if (vector_vld_i) begin
        got_o     <= 1'b1;
        got_vec_o <= vector_i;
      end
    end
  end
endmodule : cic_cpu_model

// *** bench/cascaded_irq_controller_init_pm_tb.sv ***
// Self-checking bench for the cascaded interrupt controller pair
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module cascaded_irq_controller_init_pm_tb;
  import cic_pkg::*;
  logic        ref_clk, rstn, io_wr, io_rd, inta, ack_go, got, cpu_int, vector_vld, wake, activity;
  logic [7:0]  io_addr, io_wdata, io_rdata, vector, got_vec;
  logic [15:0] irq, act_sel, qual;
  logic [2:0]  pins, pin_en, pin_map;
  logic [1:0]  sel;
  int          bad_count, samples_checked, wake_cnt, act_cnt, w;
  logic [2:0]  t_en[6]  = '{3'h7, 3'h7, 3'h7, 3'h0, 3'h7, 3'h7};
  logic [2:0]  t_map[6] = '{3'h7, 3'h7, 3'h7, 3'h7, 3'h0, 3'h7};
  logic [1:0]  t_sel[6] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h1, 2'h0};

  cic_top uut (.ref_clk_i(ref_clk), .rstn_i(rstn), .io_wr_i(io_wr), .io_rd_i(io_rd),
    .io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata), .irq_i(irq),
    .inta_i(inta), .cpu_int_o(cpu_int), .vector_o(vector), .vector_vld_o(vector_vld),
    .ext_request_pins_low_i(pins), .ext_pin_en_i(pin_en), .ext_pin_mapped_i(pin_map),
    .chip_setup_index_sel_i(sel), .act_sel_i(act_sel), .qual_irq_o(qual), .wake_o(wake),
    .activity_o(activity));
  cic_cpu_model cpu (.ref_clk_i(ref_clk), .rstn_i(rstn), .ack_go_i(ack_go),
    .vector_vld_i(vector_vld), .vector_i(vector), .inta_o(inta), .got_vec_o(got_vec), .got_o(got));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (activity === 1'b1) act_cnt++;
    if (wake === 1'b1) wake_cnt++;
  end

  // ****************************************************************
  // Port access, acknowledge and closing tasks
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    io_wr   <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge ref_clk);
    io_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk);
    io_rd   <= 1'b1;
    io_addr <= a;
    @(posedge ref_clk);
    io_rd <= 1'b0;
    @(negedge ref_clk);
    `CHK(nm, e, io_rdata)
  endtask : rd
  task automatic init(input logic [7:0] ev, input logic [7:0] w4);
    wr(ev, 8'h19);
    repeat (2) wr(ev + 8'h01, 8'h00);
    wr(ev + 8'h01, w4);
    wr(ev + 8'h01, 8'h00);
  endtask : init
  task automatic wait_int(input string nm);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (cpu_int !== 1'b1 && n < 20);
    `CHK(nm, 1'b1, cpu_int)
  endtask : wait_int
  task automatic ack(input logic [7:0] e, input string nm);
    int n;
    n = 0;
    @(posedge ref_clk);
    ack_go <= 1'b1;
    @(posedge ref_clk);
    ack_go <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (got !== 1'b1 && n < 20);
    `CHK(nm, e, got_vec)
  endtask : ack
  task automatic one_src(input int k, input logic [7:0] e);
    int a;
    a = act_cnt;
    w = wake_cnt;
    @(posedge ref_clk);
    irq[k] <= 1'b1;
    wait_int("int line");
    repeat (2) @(negedge ref_clk);
    `CHK("qual bit", 1'b1, qual[k])
    `CHK("activity", act_sel[k] ? 1 : 0, act_cnt - a)
    `CHK("no wake", 0, wake_cnt - w)
    ack(e, "vector");
    @(posedge ref_clk);
    irq[k] <= 1'b0;
    if (k > 7) wr(PORT_S_EVEN, 8'h20);
    wr(PORT_M_EVEN, 8'h20);
    @(negedge ref_clk);
    `CHK("qual idle", 16'h0000, qual)
  endtask : one_src
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    final_report();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {rstn, io_wr, io_rd, ack_go, io_addr, io_wdata, irq} = '0;
    {pins, pin_en, pin_map, sel, bad_count, samples_checked, wake_cnt, act_cnt} = '0;
    act_sel = 16'hffef;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    wr(PORT_M_EVEN, 8'h19);
    repeat (2) wr(PORT_M_ODD, 8'h00);
    wr(PORT_M_EVEN, 8'h19);
    repeat (2) wr(PORT_M_ODD, 8'hff);
    rd(PORT_M_ODD, 8'h00, "mask mid init");
    wr(PORT_M_ODD, 8'h00);
    wr(PORT_M_ODD, 8'hff);
    rd(PORT_M_ODD, 8'hff, "mask ready");
    wr(PORT_M_ODD, 8'h00);
    init(PORT_S_EVEN, 8'h00);
    $display("done: init");
    for (int k = 0; k < 8; k++) if (k != 2) one_src(k, VEC_BASE_M + 8'(k));
    for (int j = 0; j < 8; j++) one_src(j + 8, VEC_BASE_S + 8'(j));
    $display("done: vectors");
    @(posedge ref_clk);
    irq[5] <= 1'b1;
    wait_int("first");
    ack(8'h0d, "nest first");
    @(posedge ref_clk);
    irq[7] <= 1'b1;
    irq[5] <= 1'b0;
    repeat (4) @(negedge ref_clk);
    `CHK("lower blocked", 1'b0, cpu_int)
    wr(PORT_M_EVEN, 8'h0b);
    rd(PORT_M_EVEN, 8'h20, "isr read");
    wr(PORT_M_EVEN, 8'h0a);
    rd(PORT_M_EVEN, 8'h80, "irr read");
    @(posedge ref_clk);
    irq[3] <= 1'b1;
    wait_int("higher passes");
    ack(8'h0b, "nest second");
    @(posedge ref_clk);
    irq[3] <= 1'b0;
    repeat (2) wr(PORT_M_EVEN, 8'h20);
    wait_int("lowest released");
    ack(8'h0f, "nest third");
    @(posedge ref_clk);
    irq[7] <= 1'b0;
    wr(PORT_M_EVEN, 8'h20);
    ack(8'h0f, "none pending");
    $display("done: nesting");
    for (int c = 0; c < 6; c++) begin
      for (int p = 0; p < 3; p++) begin
        @(posedge ref_clk);
        pin_en  <= t_en[c];
        pin_map <= t_map[c];
        sel     <= t_sel[c];
        w = wake_cnt;
        @(posedge ref_clk);
        pins[p] <= 1'b1;
        repeat (4) @(negedge ref_clk);
        `CHK("wake", (c < 3) ? 1 : 0, wake_cnt - w)
        @(posedge ref_clk);
        pins[p] <= 1'b0;
      end
    end
    $display("done: wake");
    wr(PORT_M_ODD, 8'ha5);
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(PORT_M_ODD, 8'ha5, "mask kept");
    $display("done: reset");
    init(PORT_M_EVEN, 8'h02);
    init(PORT_S_EVEN, 8'h02);
    @(posedge ref_clk);
    irq[3] <= 1'b1;
    wait_int("auto int");
    ack(8'h0b, "auto vector");
    @(posedge ref_clk);
    irq[3] <= 1'b0;
    wr(PORT_M_EVEN, 8'h0b);
    rd(PORT_M_EVEN, 8'h00, "master auto end");
    @(posedge ref_clk);
    irq[9] <= 1'b1;
    wait_int("slave int");
    ack(8'h71, "slave vector");
    @(posedge ref_clk);
    irq[9] <= 1'b0;
    wr(PORT_S_EVEN, 8'h0b);
    rd(PORT_S_EVEN, 8'h02, "slave keeps service");
    $display("done: auto end");
    wr(PORT_M_EVEN, 8'h11);
    repeat (3) wr(PORT_M_ODD, 8'h00);
    @(posedge ref_clk);
    irq[6] <= 1'b1;
    wait_int("edge int");
    ack(8'h0e, "edge vector");
    rd(PORT_M_EVEN, 8'h00, "edge pending cleared");
    wr(PORT_M_EVEN, 8'h20);
    repeat (4) @(negedge ref_clk);
    `CHK("held level no retrigger", 1'b0, cpu_int)
    @(posedge ref_clk);
    irq[6] <= 1'b0;
    $display("done: edge mode");
    final_report();
  end
endmodule : cascaded_irq_controller_init_pm_tb
